// ==== core/uchrd_pkg.sv ====
// uchrd_pkg: locations, field positions, masks and reset values of one
// uart channel register bank.
// assumes: imported whole by every module of the channel register bank.
package uchrd_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // register locations, selected by the four low address lines
  localparam logic [3:0] LOC_HOLDING  = 4'h0;
  localparam logic [3:0] LOC_IER_DHI  = 4'h1;
  localparam logic [3:0] LOC_ISR_FCR  = 4'h2;
  localparam logic [3:0] LOC_LCR      = 4'h3;
  localparam logic [3:0] LOC_MCR      = 4'h4;
  localparam logic [3:0] LOC_LSR      = 4'h5;
  localparam logic [3:0] LOC_MSR_TDM  = 4'h6;
  localparam logic [3:0] LOC_SCRATCH  = 4'h7;
  localparam logic [3:0] LOC_FEATURE_CONTROL     = 4'h8;
  localparam logic [3:0] LOC_EFR      = 4'h9;
  localparam logic [3:0] LOC_RSVD_A   = 4'hA;
  localparam logic [3:0] LOC_RSVD_B   = 4'hB;
  localparam logic [3:0] LOC_STOP_ONE = 4'hC;
  localparam int         BANK_BIT     = 3;

  localparam int FLOW_CHAR_COUNT = 4;

  // field positions
  localparam int LCR_DIV_ACCESS_BIT = 7;
  localparam int EFR_ENH_BIT        = 4;
  localparam int FCR_ENABLE_BIT     = 0;
  localparam int FCR_RXRST_BIT      = 1;
  localparam int FCR_TXRST_BIT      = 2;
  localparam int FCR_DMA_BIT        = 3;
  localparam int FCR_TXTRIG_LO      = 4;
  localparam int FCR_RXTRIG_LO      = 6;
  localparam int TDM_NINE_BIT       = 0;
  localparam int TDM_RXDIS_BIT      = 2;
  localparam int TDM_TXDIS_BIT      = 3;
  localparam int TDM_DELAY_LO       = 4;
  localparam int FEATURE_CONTROL_IRINV_BIT     = 4;
  localparam int FEATURE_CONTROL_AUTODIR_BIT   = 5;

  // bits that exist only while the enhanced unlock is set
  localparam logic [7:0] IER_ENH_MASK  = 8'hE0;
  localparam logic [7:0] ISR_ENH_MASK  = 8'h30;
  localparam logic [7:0] FCR_ENH_MASK  = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK  = 8'hEC;
  localparam logic [7:0] TDM_ENH_MASK  = 8'hFF;
  // implemented bits of each register
  localparam logic [7:0] IER_MASK      = 8'hEF;
  localparam logic [7:0] DFRAC_MASK    = 8'h0F;
  localparam logic [7:0] FCR_KEEP_MASK = 8'hF9;
  localparam logic [7:0] TDM_MASK      = 8'hFD;
  localparam logic [7:0] FEATURE_CONTROL_MASK     = 8'h30;
  localparam logic [7:0] ALL_ZERO      = 8'h00;

  // reset values
  localparam logic [7:0] DIV_LOW_RESET   = 8'h01;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] FLOW_CHAR_RESET = 8'h00;

  // hides enhanced-only bits while the unlock is clear
  function automatic logic [7:0] uchrd_gate(input logic [7:0] value,
                                            input logic [7:0] enhMask,
                                            input logic       unlocked);
    uchrd_gate = unlocked ? value : (value & ~enhMask);
  endfunction

endpackage

// ==== core/uchrd_read_mux.sv ====
// uchrd_read_mux: selects the byte that a host read returns.
// assumes: inputs already carry enhanced gating where the caller owns it.
`timescale 1ns/1ps
module uchrd_read_mux
  import uchrd_pkg::*;
(
  input  wire logic [3:0] regAddr,
  input  wire logic       divAccess,
  input  wire logic       enhUnlock,
  input  wire logic [7:0] rxHoldingByte,
  input  wire logic [7:0] divisorLow,
  input  wire logic [7:0] divisorHigh,
  input  wire logic [7:0] divisorFraction,
  input  wire logic [7:0] interruptEnable,
  input  wire logic [3:0] intSourceIn,
  input  wire logic [1:0] intFlowIn,
  input  wire logic       fifoEnable,
  input  wire logic [7:0] lineControl,
  input  wire logic [7:0] modemControl,
  input  wire logic [7:0] lineStatusIn,
  input  wire logic [3:0] modemLinesIn,
  input  wire logic [3:0] modemDeltaIn,
  input  wire logic [7:0] scratchByte,
  input  wire logic [7:0] featureControl,
  input  wire logic [7:0] enhancedFunction,
  input  wire logic [3:0] flowFlagsIn,
  output logic      [7:0] readValue
);

  logic [7:0] isrValue;

  always_comb begin
    isrValue = uchrd_gate({fifoEnable, fifoEnable, intFlowIn, intSourceIn},
                          ISR_ENH_MASK, enhUnlock);
  end

  always_comb begin
    case (regAddr)
      LOC_HOLDING: readValue = divAccess ? divisorLow : rxHoldingByte;
      LOC_IER_DHI: readValue = divAccess ? divisorHigh : interruptEnable;
      LOC_ISR_FCR: readValue = divAccess ? (divisorFraction & DFRAC_MASK)
                                         : isrValue;
      LOC_LCR:     readValue = lineControl;
      LOC_MCR:     readValue = modemControl;
      LOC_LSR:     readValue = lineStatusIn;
      LOC_MSR_TDM: readValue = {modemLinesIn, modemDeltaIn};
      LOC_SCRATCH: readValue = scratchByte;
      LOC_FEATURE_CONTROL:    readValue = featureControl & FEATURE_CONTROL_MASK;
      LOC_EFR:     readValue = enhancedFunction;
      LOC_STOP_ONE: readValue = {4'h0, flowFlagsIn};
      default:     readValue = ALL_ZERO;
    endcase
  end

endmodule

// ==== core/uchrd_regs.sv ====
// uchrd_regs: register bank of one uart channel, reached by the host over
// a parallel bus with four address lines, chip select and strobes.
// assumes: strobes and address are synchronous to ref_clk; one channel
// select per instance; datapath status arrives as plain inputs.
`timescale 1ns/1ps
module uchrd_regs
  import uchrd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // host register bus
  input  wire logic       chipSelect,
  input  wire logic [3:0] regAddr,
  input  wire logic       writeStrobe,
  input  wire logic [7:0] writeData,
  input  wire logic       readStrobe,
  output logic      [7:0] readData,
  // status from the channel datapath
  input  wire logic [7:0] rxHoldingByte,
  input  wire logic [3:0] intSourceIn,
  input  wire logic [1:0] intFlowIn,
  input  wire logic [7:0] lineStatusIn,
  input  wire logic [3:0] modemLinesIn,
  input  wire logic [3:0] modemDeltaIn,
  input  wire logic [3:0] flowFlagsIn,
  // access side effects
  output logic      [7:0] transmitHolding,
  output logic            txLoad,
  output logic            rxRead,
  output logic            lineStatusRead,
  output logic            modemStatusRead,
  output logic            flowFlagsRead,
  output logic            txFifoReset,
  output logic            rxFifoReset,
  // configuration to the channel datapath
  output logic      [7:0] divisorLow,
  output logic      [7:0] divisorHigh,
  output logic      [3:0] divisorFraction,
  output logic      [7:0] interruptEnable,
  output logic      [1:0] rxTrigger,
  output logic      [1:0] txTrigger,
  output logic            dmaMode,
  output logic            fifoEnable,
  output logic      [7:0] lineControl,
  output logic      [7:0] modemControl,
  output logic      [3:0] turnaroundDelay,
  output logic            txDisable,
  output logic            rxDisable,
  output logic            nineBitMode,
  output logic            autoDirection,
  output logic            irRxInvert,
  output logic      [7:0] enhancedFunction,
  output logic      [7:0] stopCharOne,
  output logic      [7:0] stopCharTwo,
  output logic      [7:0] startCharOne,
  output logic      [7:0] startCharTwo
);

  logic [7:0] divLow_reg;
  logic [7:0] divHigh_reg;
  logic [7:0] divFrac_reg;
  logic [7:0] ier_reg;
  logic [7:0] fcr_reg;
  logic [7:0] lcr_reg;
  logic [7:0] mcr_reg;
  logic [7:0] tdm_reg;
  logic [7:0] scratch_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] efr_reg;
  logic [7:0] thr_reg;
  logic [7:0] readData_reg;
  logic [7:0] flowChar_reg [FLOW_CHAR_COUNT];
  logic       txLoad_reg;
  logic       rxRead_reg;
  logic       lsrRead_reg;
  logic       msrRead_reg;
  logic       flagsRead_reg;
  logic       txRst_reg;
  logic       rxRst_reg;

  logic       wrAccess;
  logic       rdAccess;
  logic       divAccess;
  logic       enhUnlock;
  logic [7:0] ierView;
  logic [7:0] fcrView;
  logic [7:0] mcrView;
  logic [7:0] tdmView;
  logic [7:0] readValue;

  // true when the address hits the given location, in either view
  function automatic logic uchrd_hit(input logic [3:0] addr,
                                     input logic [3:0] loc);
    uchrd_hit = (addr == loc);
  endfunction

  // true for a location of the plain view, the one seen with divisor access clear
  function automatic logic uchrd_plain_hit(input logic [3:0] addr,
                                           input logic [3:0] loc,
                                           input logic       dacc);
    uchrd_plain_hit = !dacc && uchrd_hit(addr, loc);
  endfunction

  // write wins when both strobes arrive together
  assign wrAccess  = chipSelect && writeStrobe;
  assign rdAccess  = chipSelect && readStrobe && !writeStrobe;
  assign divAccess = lcr_reg[LCR_DIV_ACCESS_BIT];
  assign enhUnlock = efr_reg[EFR_ENH_BIT];

  // enhanced-only fields drop out while the unlock is clear
  assign ierView = uchrd_gate(ier_reg & IER_MASK, IER_ENH_MASK, enhUnlock);
  assign fcrView = uchrd_gate(fcr_reg, FCR_ENH_MASK, enhUnlock);
  assign mcrView = uchrd_gate(mcr_reg, MCR_ENH_MASK, enhUnlock);
  assign tdmView = uchrd_gate(tdm_reg & TDM_MASK, TDM_ENH_MASK, enhUnlock);

  // divisor latches, reachable only with divisor access set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divLow_reg  <= DIV_LOW_RESET;
      divHigh_reg <= REG_RESET;
      divFrac_reg <= REG_RESET;
    end else if (wrAccess && divAccess) begin
      if (uchrd_hit(regAddr, LOC_HOLDING)) begin
        divLow_reg <= writeData;
      end
      if (uchrd_hit(regAddr, LOC_IER_DHI)) begin
        divHigh_reg <= writeData;
      end
      if (uchrd_hit(regAddr, LOC_ISR_FCR)) begin
        divFrac_reg <= writeData & DFRAC_MASK;
      end
    end
  end

  // transmit holding byte and its load pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_reg    <= REG_RESET;
      txLoad_reg <= 1'b0;
    end else begin
      txLoad_reg <= 1'b0;
      if (wrAccess && uchrd_plain_hit(regAddr, LOC_HOLDING, divAccess)) begin
        thr_reg    <= writeData;
        txLoad_reg <= 1'b1;
      end
    end
  end

  // interrupt enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ier_reg <= REG_RESET;
    end else if (wrAccess && uchrd_plain_hit(regAddr, LOC_IER_DHI, divAccess)) begin
      ier_reg <= writeData & IER_MASK;
    end
  end

  // fifo control; the two fifo reset bits are pulses, not stored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fcr_reg   <= REG_RESET;
      txRst_reg <= 1'b0;
      rxRst_reg <= 1'b0;
    end else begin
      txRst_reg <= 1'b0;
      rxRst_reg <= 1'b0;
      if (wrAccess && uchrd_plain_hit(regAddr, LOC_ISR_FCR, divAccess)) begin
        fcr_reg   <= writeData & FCR_KEEP_MASK;
        txRst_reg <= writeData[FCR_TXRST_BIT];
        rxRst_reg <= writeData[FCR_RXRST_BIT];
      end
    end
  end

  // line control, independent of divisor access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lcr_reg <= REG_RESET;
    end else if (wrAccess && uchrd_hit(regAddr, LOC_LCR)) begin
      lcr_reg <= writeData;
    end
  end

  // modem control
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcr_reg <= REG_RESET;
    end else if (wrAccess && uchrd_hit(regAddr, LOC_MCR)) begin
      mcr_reg <= writeData;
    end
  end

  // turnaround delay and mode, write side of the modem status location
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdm_reg <= REG_RESET;
    end else if (wrAccess && enhUnlock && uchrd_hit(regAddr, LOC_MSR_TDM)) begin
      tdm_reg <= writeData & TDM_MASK;
    end
  end

  // scratch byte, read back only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scratch_reg <= REG_RESET;
    end else if (wrAccess && uchrd_hit(regAddr, LOC_SCRATCH)) begin
      scratch_reg <= writeData;
    end
  end

  // feature control in the upper bank
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      feature_control_reg <= REG_RESET;
    end else if (wrAccess && regAddr[BANK_BIT] && uchrd_hit(regAddr, LOC_FEATURE_CONTROL)) begin
      feature_control_reg <= writeData & FEATURE_CONTROL_MASK;
    end
  end

  // enhanced function, holder of the unlock bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      efr_reg <= REG_RESET;
    end else if (wrAccess && uchrd_hit(regAddr, LOC_EFR)) begin
      efr_reg <= writeData;
    end
  end

  // flow characters at the four top locations; reserved 10 and 11 hold nothing
  for (genvar i = 0; i < FLOW_CHAR_COUNT; i++) begin : gFlowChar
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        flowChar_reg[i] <= FLOW_CHAR_RESET;
      end else if (wrAccess && uchrd_hit(regAddr, LOC_STOP_ONE + 4'(i))) begin
        flowChar_reg[i] <= writeData;
      end
    end
  end

  uchrd_read_mux uReadMux (
    .regAddr          (regAddr),
    .divAccess        (divAccess),
    .enhUnlock        (enhUnlock),
    .rxHoldingByte    (rxHoldingByte),
    .divisorLow       (divLow_reg),
    .divisorHigh      (divHigh_reg),
    .divisorFraction  (divFrac_reg),
    .interruptEnable  (ierView),
    .intSourceIn      (intSourceIn),
    .intFlowIn        (intFlowIn),
    .fifoEnable       (fcr_reg[FCR_ENABLE_BIT]),
    .lineControl      (lcr_reg),
    .modemControl     (mcrView),
    .lineStatusIn     (lineStatusIn),
    .modemLinesIn     (modemLinesIn),
    .modemDeltaIn     (modemDeltaIn),
    .scratchByte      (scratch_reg),
    .featureControl   (feature_control_reg),
    .enhancedFunction (efr_reg),
    .flowFlagsIn      (flowFlagsIn),
    .readValue        (readValue)
  );

  // read data register; holds until the next read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readData_reg <= REG_RESET;
    end else if (rdAccess) begin
      readData_reg <= readValue;
    end
  end

  // receive pop on a plain-view holding read, aligned with readData
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxRead_reg <= 1'b0;
    end else begin
      rxRead_reg <= rdAccess && uchrd_plain_hit(regAddr, LOC_HOLDING, divAccess);
    end
  end

  // status reads let the datapath clear its flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lsrRead_reg   <= 1'b0;
      msrRead_reg   <= 1'b0;
      flagsRead_reg <= 1'b0;
    end else begin
      lsrRead_reg   <= rdAccess && uchrd_hit(regAddr, LOC_LSR);
      msrRead_reg   <= rdAccess && uchrd_hit(regAddr, LOC_MSR_TDM);
      flagsRead_reg <= rdAccess && uchrd_hit(regAddr, LOC_STOP_ONE);
    end
  end

  assign readData        = readData_reg;
  assign transmitHolding = thr_reg;
  assign txLoad          = txLoad_reg;
  assign rxRead          = rxRead_reg;
  assign lineStatusRead  = lsrRead_reg;
  assign modemStatusRead = msrRead_reg;
  assign flowFlagsRead   = flagsRead_reg;
  assign txFifoReset     = txRst_reg;
  assign rxFifoReset     = rxRst_reg;

  assign divisorLow      = divLow_reg;
  assign divisorHigh     = divHigh_reg;
  assign divisorFraction = divFrac_reg[3:0];
  assign interruptEnable = ierView;
  assign rxTrigger       = fcrView[FCR_RXTRIG_LO +: 2];
  assign txTrigger       = fcrView[FCR_TXTRIG_LO +: 2];
  assign dmaMode         = fcrView[FCR_DMA_BIT];
  assign fifoEnable      = fcrView[FCR_ENABLE_BIT];
  assign lineControl     = lcr_reg;
  assign modemControl    = mcrView;
  assign turnaroundDelay = tdmView[TDM_DELAY_LO +: 4];
  assign txDisable       = tdmView[TDM_TXDIS_BIT];
  assign rxDisable       = tdmView[TDM_RXDIS_BIT];
  assign nineBitMode     = tdmView[TDM_NINE_BIT];
  assign autoDirection   = feature_control_reg[FEATURE_CONTROL_AUTODIR_BIT];
  assign irRxInvert      = feature_control_reg[FEATURE_CONTROL_IRINV_BIT];
  assign enhancedFunction = efr_reg;
  assign stopCharOne     = flowChar_reg[0];
  assign stopCharTwo     = flowChar_reg[1];
  assign startCharOne    = flowChar_reg[2];
  assign startCharTwo    = flowChar_reg[3];

endmodule

// ==== tb/tb_top.sv ====
// tb_top: self-checking bench for the channel register bank.
// assumes: host model drives the bus; datapath status comes from this bench.
`timescale 1ns/1ps
module tb_top;
  logic       ref_clk, rst_n, chipSelect, writeStrobe, readStrobe, u;
  logic [3:0] regAddr, intSourceIn, modemLinesIn, modemDeltaIn, flowFlagsIn;
  logic [3:0] divisorFraction, turnaroundDelay;
  logic [1:0] intFlowIn, rxTrigger, txTrigger;
  logic [7:0] writeData, readData, rxHoldingByte, lineStatusIn, transmitHolding;
  logic [7:0] divisorLow, divisorHigh, interruptEnable, lineControl, modemControl;
  logic [7:0] stopCharOne, stopCharTwo, startCharOne, startCharTwo, rv, w;
  logic       dmaMode, fifoEnable, txDisable, rxDisable, nineBitMode, autoDirection;
  logic       irRxInvert, rxRead, lineStatusRead, modemStatusRead, flowFlagsRead;
  logic [7:0] lastW [16];
  integer     seed = 19378;
  int         err_count = 0;
  int         n_compared = 0;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  uchrd_host_model u_host (.ref_clk(ref_clk), .chipSelect(chipSelect), .regAddr(regAddr),
    .writeStrobe(writeStrobe), .writeData(writeData), .readStrobe(readStrobe),
    .readData(readData));

  uchrd_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .chipSelect(chipSelect),
    .regAddr(regAddr), .writeStrobe(writeStrobe), .writeData(writeData),
    .readStrobe(readStrobe), .readData(readData), .rxHoldingByte(rxHoldingByte),
    .intSourceIn(intSourceIn), .intFlowIn(intFlowIn), .lineStatusIn(lineStatusIn),
    .modemLinesIn(modemLinesIn), .modemDeltaIn(modemDeltaIn), .flowFlagsIn(flowFlagsIn),
    .transmitHolding(transmitHolding), .txLoad(), .rxRead(rxRead),
    .lineStatusRead(lineStatusRead), .modemStatusRead(modemStatusRead),
    .flowFlagsRead(flowFlagsRead), .txFifoReset(), .rxFifoReset(),
    .divisorLow(divisorLow), .divisorHigh(divisorHigh), .divisorFraction(divisorFraction),
    .interruptEnable(interruptEnable), .rxTrigger(rxTrigger), .txTrigger(txTrigger),
    .dmaMode(dmaMode), .fifoEnable(fifoEnable), .lineControl(lineControl),
    .modemControl(modemControl), .turnaroundDelay(turnaroundDelay), .txDisable(txDisable),
    .rxDisable(rxDisable), .nineBitMode(nineBitMode), .autoDirection(autoDirection),
    .irRxInvert(irRxInvert), .enhancedFunction(), .stopCharOne(stopCharOne),
    .stopCharTwo(stopCharTwo), .startCharOne(startCharOne), .startCharTwo(startCharTwo));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // expected read of each location with divisor access clear
  function automatic logic [7:0] exp_rd(input logic [3:0] a);
    case (a)
      4'h0: exp_rd = rxHoldingByte;
      4'h1: exp_rd = lastW[1] & (u ? 8'hEF : 8'h0F);
      4'h2: exp_rd = {{2{lastW[2][0]}}, u ? intFlowIn : 2'b00, intSourceIn};
      4'h3, 4'h7, 4'h9: exp_rd = lastW[a];
      4'h4: exp_rd = lastW[4] & (u ? 8'hFF : 8'h13);
      4'h5: exp_rd = lineStatusIn;
      4'h6: exp_rd = {modemLinesIn, modemDeltaIn};
      4'h8: exp_rd = lastW[8] & 8'h30;
      4'hC: exp_rd = {4'h0, flowFlagsIn};
      default: exp_rd = 8'h00;
    endcase
  endfunction

  initial begin
    repeat (50000) @(posedge ref_clk);
    err_count++;
    $display("unexpected run length: expected end seen none");
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    {rxHoldingByte, intSourceIn, intFlowIn, lineStatusIn} = '0;
    {modemLinesIn, modemDeltaIn, flowFlagsIn} = '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("divisorLow", 8'h01, divisorLow);
    check("lineControl", 8'h00, lineControl);
    w = 8'h80 | 8'($random(seed));
    u_host.bus_write(4'h3, w, 0);
    for (int a = 0; a < 3; a++) begin
      lastW[a] = 8'($random(seed));
      u_host.bus_write(4'(a), lastW[a], 0);
      u_host.bus_read(4'(a), rv, 1);
      check("rxRead", 8'h00, {7'h00, rxRead});
      check("divisor", (a == 2) ? (lastW[a] & 8'h0F) : lastW[a], rv);
    end
    check("divisorHigh", lastW[1], divisorHigh);
    check("divisorFraction", {4'h0, lastW[2][3:0]}, {4'h0, divisorFraction});
    u_host.bus_read(4'h3, rv, 0);
    check("lineControl", w, rv);
    u_host.bus_write(4'h3, 8'h00, 0);
    // alternate locked and unlocked passes over all sixteen locations
    for (int p = 0; p < 6; p++) begin
      u = p[0];
      @(posedge ref_clk);
      rxHoldingByte <= 8'($random(seed));
      {intSourceIn, intFlowIn, modemLinesIn} <= 10'($random(seed));
      {lineStatusIn, modemDeltaIn, flowFlagsIn} <= 16'($random(seed));
      for (int a = 0; a < 16; a++) begin
        w = 8'($random(seed));
        if (a == 3) w[7] = 1'b0;
        if (a == 9 || a == 0) u_host.bus_write(4'h9, {w[7:5], u, w[3:0]}, 0);
        if (a == 9) w[4] = u;
        lastW[a] = w;
        u_host.bus_write(4'(a), w, $unsigned($random(seed)) % 3);
        u_host.bus_read(4'(a), rv, 0);
        check("readPulses", {4'h0, a == 0, a == 5, a == 6, a == 12},
              {4'h0, rxRead, lineStatusRead, modemStatusRead, flowFlagsRead});
        check("readback", exp_rd(4'(a)), rv);
      end
      check("transmitHolding", lastW[0], transmitHolding);
      check("interruptEnable", lastW[1] & (u ? 8'hEF : 8'h0F), interruptEnable);
      check("fifoControl", {2'b00, lastW[2][7:6], u ? lastW[2][5:4] : 2'b00, lastW[2][3],
            lastW[2][0]}, {2'b00, rxTrigger, txTrigger, dmaMode, fifoEnable});
      check("modemControl", lastW[4] & (u ? 8'hFF : 8'h13), modemControl);
      check("turnaround", u ? {1'b0, lastW[6][7:2], lastW[6][0]} : 8'h00,
            {1'b0, turnaroundDelay, txDisable, rxDisable, nineBitMode});
      check("featureControl", {6'h00, lastW[8][5:4]}, {6'h00, autoDirection, irRxInvert});
      check("stopCharOne", lastW[12], stopCharOne);
      check("stopCharTwo", lastW[13], stopCharTwo);
      check("startCharOne", lastW[14], startCharOne);
      check("startCharTwo", lastW[15], startCharTwo);
    end
    tally_and_finish();
  end
endmodule

// ==== tb/uchrd_host_model.sv ====
// uchrd_host_model: host processor on the parallel register bus.
// assumes: one access per call, request taken on the edge after it is driven.
`timescale 1ns/1ps
module uchrd_host_model (
  input  wire logic       ref_clk,
  output logic            chipSelect,
  output logic      [3:0] regAddr,
  output logic            writeStrobe,
  output logic      [7:0] writeData,
  output logic            readStrobe,
  input  wire logic [7:0] readData
);
  initial begin
    chipSelect  = 1'b0;
    regAddr     = 4'h0;
    writeStrobe = 1'b0;
    writeData   = 8'h00;
    readStrobe  = 1'b0;
  end

  // slow host: idle cycles with a released bus that shows no stale value
  task automatic idle(input int gap);
    repeat (gap) begin
      @(posedge ref_clk);
      writeData <= ~writeData;
      regAddr   <= ~regAddr;
    end
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d, input int gap);
    idle(gap);
    @(posedge ref_clk);
    chipSelect  <= 1'b1;
    regAddr     <= a;
    writeStrobe <= 1'b1;
    writeData   <= d;
    @(posedge ref_clk);
    chipSelect  <= 1'b0;
    writeStrobe <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [7:0] d, input int gap);
    idle(gap);
    @(posedge ref_clk);
    chipSelect <= 1'b1;
    regAddr    <= a;
    readStrobe <= 1'b1;
    @(posedge ref_clk);
    chipSelect <= 1'b0;
    readStrobe <= 1'b0;
    #1;
    d = readData;
  endtask
endmodule

// ==== tb/uchrd_regs_props.sv ====
// uchrd_regs_props: concurrent checks on the channel register bank ports.
// assumes: bound to every uchrd_regs instance, single clock domain.
`timescale 1ns/1ps
module uchrd_regs_props (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       chipSelect,
  input wire logic [3:0] regAddr,
  input wire logic       writeStrobe,
  input wire logic [7:0] writeData,
  input wire logic       readStrobe,
  input wire logic [7:0] readData,
  input wire logic [7:0] lineStatusIn,
  input wire logic [7:0] transmitHolding,
  input wire logic       txLoad,
  input wire logic       lineStatusRead,
  input wire logic       txFifoReset,
  input wire logic       rxFifoReset,
  input wire logic [7:0] divisorLow,
  input wire logic [7:0] interruptEnable,
  input wire logic [7:0] lineControl,
  input wire logic [7:0] modemControl,
  input wire logic [7:0] enhancedFunction
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic wr;
  logic rd;
  logic dacc;
  assign wr   = chipSelect && writeStrobe;
  assign rd   = chipSelect && readStrobe && !writeStrobe;
  assign dacc = lineControl[7];

  a_tx_load_data: assert property (wr && regAddr == 4'h0 && !dacc
    |=> txLoad && transmitHolding == $past(writeData)) else $error("tx load wrong");
  a_tx_load_cause: assert property (!(wr && regAddr == 4'h0 && !dacc) |=> !txLoad)
    else $error("stray tx load");
  a_div_low_write: assert property (wr && regAddr == 4'h0 && dacc
    |=> divisorLow == $past(writeData) && !txLoad) else $error("divisor low wrong");
  a_frac_top_zero: assert property (rd && regAddr == 4'h2 && dacc
    |=> readData[7:4] == 4'h0) else $error("fraction top bits set");
  a_fifo_reset: assert property (wr && regAddr == 4'h2 && !dacc
    |=> txFifoReset == $past(writeData[2])) else $error("tx fifo reset wrong");
  a_rx_fifo_reset: assert property (wr && regAddr == 4'h2 && !dacc
    |=> rxFifoReset == $past(writeData[1])) else $error("rx fifo reset wrong");
  a_fifo_rst_cause: assert property (!(wr && regAddr == 4'h2 && !dacc)
    |=> !rxFifoReset && !txFifoReset) else $error("stray fifo reset");
  a_lcr_write: assert property (wr && regAddr == 4'h3
    |=> lineControl == $past(writeData)) else $error("line control wrong");
  a_lsr_read: assert property (rd && regAddr == 4'h5
    |=> readData == $past(lineStatusIn) && lineStatusRead) else $error("line status wrong");
  a_enh_hidden: assert property (!enhancedFunction[4]
    |-> interruptEnable[7:4] == 4'h0 && (modemControl & 8'hEC) == 8'h00)
    else $error("enhanced bits visible while locked");
  a_rsvd_zero: assert property (rd && (regAddr == 4'hA || regAddr == 4'hB)
    |=> readData == 8'h00) else $error("reserved read not zero");
  a_read_holds: assert property (!rd |=> $stable(readData))
    else $error("read data moved without read");
endmodule

bind uchrd_regs uchrd_regs_props u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .chipSelect(chipSelect), .regAddr(regAddr),
  .writeStrobe(writeStrobe), .writeData(writeData), .readStrobe(readStrobe),
  .readData(readData), .lineStatusIn(lineStatusIn), .transmitHolding(transmitHolding),
  .txLoad(txLoad), .lineStatusRead(lineStatusRead), .txFifoReset(txFifoReset),
  .rxFifoReset(rxFifoReset),
  .divisorLow(divisorLow), .interruptEnable(interruptEnable), .lineControl(lineControl),
  .modemControl(modemControl), .enhancedFunction(enhancedFunction)
);
